// >>> lcrm_pkg.sv
// Purpose: shared constants and types for the programmable logic cell block
// Assumes: APB register access, 32-bit data, one word per register
// Notes:   field positions and encodings are used by the cell and its bench
package lcrm_pkg;

	// register byte addresses
	localparam logic [11:0] LCRM_ADDR_CFG  = 12'h000;
	localparam logic [11:0] LCRM_ADDR_LUT  = 12'h004;
	localparam logic [11:0] LCRM_ADDR_STAT = 12'h008;

	// configuration register field positions
	localparam int LCRM_CFG_OP_LSB   = 0;   // two bits, operating mode
	localparam int LCRM_CFG_CTL_LSB  = 2;   // three bits, clear/preset mode
	localparam int LCRM_CFG_PACKED   = 5;
	localparam int LCRM_CFG_LOC_REG  = 6;   // local output from register
	localparam int LCRM_CFG_GLB_REG  = 7;   // global output from register
	localparam int LCRM_CFG_DEV_RST  = 8;   // device-wide reset enable
	localparam int LCRM_CFG_CE_D1    = 9;   // clock enable from first data input
	localparam int LCRM_CFG_CIN_LUT  = 10;  // carry-in replaces third input in lut

	// status register field positions
	localparam int LCRM_ST_CELL      = 0;
	localparam int LCRM_ST_CLR       = 1;
	localparam int LCRM_ST_PRE       = 2;
	localparam int LCRM_ST_BUS       = 3;
	localparam int LCRM_ST_DEVRST    = 4;

	// reset values
	localparam logic [15:0] LCRM_LUT_RST = 16'h0000;
	localparam logic [31:0] LCRM_ZERO32  = 32'h0000_0000;

	// tri-state emulation width
	localparam int LCRM_TRI_N = 4;

	typedef enum logic [1:0] {
		OP_NORMAL,
		OP_ARITH,
		OP_UPDOWN,
		OP_CLRCNT
	} lcrm_op_e;

	typedef enum logic [2:0] {
		CTL_CLR,
		CTL_PRE,
		CTL_CLR_PRE,
		CTL_LOAD_CLR,
		CTL_LOAD_PRE,
		CTL_LOAD
	} lcrm_ctl_e;

	typedef struct packed {
		logic      cin_lut;
		logic      ce_d1;
		logic      dev_rst_en;
		logic      glb_reg;
		logic      loc_reg;
		logic      packed_en;
		lcrm_ctl_e ctl;
		lcrm_op_e  op;
	} lcrm_cfg_s;

	// asynchronous register controls: clear and preset active low, inversion flag active high
	typedef struct packed {
		logic clr_n;
		logic pre_n;
		logic inv;
	} lcrm_async_s;

endpackage : lcrm_pkg

// >>> lcrm_cell.sv
// Purpose: one programmable logic cell with lut, register, carry and cascade paths
// Assumes: cell inputs synchronous to pclk except the asynchronous register controls
// Notes:   configuration and lut mask are written over APB; zero wait states
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps

// Functional notes
// [R1] packed: fourth input feeds register, lut computes 3-input function of others
// [R2] packed register keeps clock enable, clear and preset
// [R3] local and global outputs each select register or lut
// [R4] arithmetic: two 3-input luts on carry-in and two inputs, sum and carry
// [R5] cascade path stays usable in arithmetic mode
// [R6] up/down counter: count enable, clock enable, direction, load
// [R7] 2-to-1 selector picks count or load data, loading synchronously
// [R8] counters also load asynchronously through clear and preset
// [R9] clearable counter: synchronous clear replaces direction on cascade input
// [R10] load selector output ANDed with synchronous clear, forcing zero
// [R11] emulated bus: several enables give low, none gives high
// [R12] async clear/preset driven only by third input and two block controls
// [R13] asynchronous load: block control one places third input into register
// [R14] clear and preset active low; unused ones held high
// [R15] six control modes: clear, preset, both, load+clear, load+preset, load
// [R16] enabled device reset clears register over every other control
// [R17] inverted preset register may read one under device reset
// [R18] clear-only: either block control clears, preset inactive
// [R19] preset-only: third input tied high, block control one loads one
// [R20] clear-with-preset: control one presets, control two clears
// [R21] load-with-clear: control one loads via both inputs, two clears only
// [R22] load-with-preset: inverted storage, control two presets, one loads
// [R23] synchronous clock enable in every mode, optionally from first input
// [R24] enabled and no async control: register captures selected input
module lcrm_cell
	import lcrm_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  first_data_input,
	input  wire logic                  second_data_input,
	input  wire logic                  third_data_input,
	input  wire logic                  fourth_data_input,
	input  wire logic                  carry_in,
	input  wire logic                  cascade_in,
	input  wire logic                  block_control_one,
	input  wire logic                  block_control_two,
	input  wire logic                  device_reset_n,
	input  wire logic [LCRM_TRI_N-1:0] tri_data,
	input  wire logic [LCRM_TRI_N-1:0] tri_enable,
	output logic                       local_out,
	output logic                       global_out,
	output logic                       carry_out,
	output logic                       cascade_out,
	output logic                       tri_bus_out
);

	lcrm_cfg_s   cfg_q;
	logic [15:0] lut_q;
	logic [31:0] prdata_q;
	logic        store_q;       // raw flop, inverted when storage is inverted
	logic        cell_q;        // register value as seen by the fabric
	lcrm_async_s actl;
	logic        dev_rst;
	logic        ce;
	logic        reg_d;         // selected next value, true polarity
	logic        store_d;
	logic        comb_out;
	logic [3:0]  lut_idx;
	logic        lut4;
	logic        lut3;
	logic        sum_bit;
	logic        arith_cout;
	logic        cnt_t;
	logic        cnt_val;
	logic        cnt_cout;
	logic        ld_mux;
	logic        acc_wr;
	logic        acc_rd_setup;
	logic        addr_hit;
	logic [LCRM_TRI_N-1:0] tri_sel;
	logic [2:0]  tri_cnt;

	// apb decode; every register answers without wait states
	assign acc_wr       = psel & penable & pwrite;
	assign acc_rd_setup = psel & ~penable & ~pwrite;
	assign addr_hit     = (paddr == LCRM_ADDR_CFG) | (paddr == LCRM_ADDR_LUT) |
	                      (paddr == LCRM_ADDR_STAT);
	assign pready       = 1'b1;
	assign pslverr      = psel & penable & ~addr_hit;
	assign prdata       = prdata_q;

	// configuration register; a write to status is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= '0;
		end else if (acc_wr && paddr == LCRM_ADDR_CFG) begin
			cfg_q.op         <= lcrm_op_e'(pwdata[LCRM_CFG_OP_LSB +: 2]);
			cfg_q.ctl        <= lcrm_ctl_e'(pwdata[LCRM_CFG_CTL_LSB +: 3]);
			cfg_q.packed_en  <= pwdata[LCRM_CFG_PACKED];
			cfg_q.loc_reg    <= pwdata[LCRM_CFG_LOC_REG];
			cfg_q.glb_reg    <= pwdata[LCRM_CFG_GLB_REG];
			cfg_q.dev_rst_en <= pwdata[LCRM_CFG_DEV_RST];
			cfg_q.ce_d1      <= pwdata[LCRM_CFG_CE_D1];
			cfg_q.cin_lut    <= pwdata[LCRM_CFG_CIN_LUT];
		end
	end

	// lut mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lut_q <= LCRM_LUT_RST;
		end else if (acc_wr && paddr == LCRM_ADDR_LUT) begin
			lut_q <= pwdata[15:0];
		end
	end

	// read data captured in the setup cycle so it is stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= LCRM_ZERO32;
		end else if (acc_rd_setup) begin
			prdata_q <= LCRM_ZERO32;
			case (paddr)
				LCRM_ADDR_CFG: begin
					prdata_q[LCRM_CFG_CIN_LUT:0] <= cfg_q;
				end
				LCRM_ADDR_LUT: begin
					prdata_q[15:0] <= lut_q;
				end
				LCRM_ADDR_STAT: begin
					prdata_q[LCRM_ST_CELL]   <= cell_q;
					prdata_q[LCRM_ST_CLR]    <= ~actl.clr_n;
					prdata_q[LCRM_ST_PRE]    <= ~actl.pre_n;
					prdata_q[LCRM_ST_BUS]    <= tri_bus_out;
					prdata_q[LCRM_ST_DEVRST] <= dev_rst;
				end
				default: begin
					prdata_q <= LCRM_ZERO32;
				end
			endcase
		end
	end

	// lut lookups; packed use drops the fourth input from the lut
	assign lut_idx    = {fourth_data_input, cfg_q.cin_lut ? carry_in : third_data_input,
	                     second_data_input, first_data_input};
	assign lut4       = lut_q[lut_idx];
	assign lut3       = lut_q[{1'b0, lut_idx[2:0]}];                       // [R1]
	assign sum_bit    = lut_q[{1'b0, carry_in, second_data_input, first_data_input}]; // [R4]
	assign arith_cout = lut_q[{1'b1, carry_in, second_data_input, first_data_input}]; // [R4]

	// counter slice: second input enables counting, carry-in is the lower carry
	assign cnt_t   = second_data_input & carry_in;                          // [R6]
	assign cnt_val = cell_q ^ cnt_t;
	always_comb begin
		// cascade input means count up only in the up/down counter
		if (cfg_q.op == OP_UPDOWN && !cascade_in) begin
			cnt_cout = ~cell_q & cnt_t;                                     // [R6]
		end else begin
			cnt_cout = cell_q & cnt_t;
		end
	end
	// fourth input strobes a synchronous load of the third input
	assign ld_mux = fourth_data_input ? third_data_input : cnt_val;        // [R7]

	// combinational result and next register value for each operating mode
	always_comb begin
		comb_out  = lut4;
		reg_d     = lut4;
		carry_out = 1'b0;
		case (cfg_q.op)
			OP_NORMAL: begin
				comb_out = cfg_q.packed_en ? lut3 : lut4;
				reg_d    = cfg_q.packed_en ? fourth_data_input : lut4;    // [R1] [R2]
			end
			OP_ARITH: begin
				comb_out  = sum_bit;
				reg_d     = sum_bit;                                       // [R4]
				carry_out = arith_cout;
			end
			OP_UPDOWN: begin
				comb_out  = cnt_val;
				reg_d     = ld_mux;                                        // [R6] [R7]
				carry_out = cnt_cout;
			end
			OP_CLRCNT: begin
				comb_out  = cnt_val;
				reg_d     = ld_mux & ~cascade_in;                          // [R9] [R10]
				carry_out = cnt_cout;
			end
			default: begin
				comb_out  = lut4;
				reg_d     = lut4;
				carry_out = 1'b0;
			end
		endcase
	end

	// cascade combines with and in lut modes; counters consume cascade-in as control
	assign cascade_out = (cfg_q.op == OP_NORMAL || cfg_q.op == OP_ARITH) ?
	                     (comb_out & cascade_in) : comb_out;                // [R5] [R9]

	// outputs select independently, so register and lut may split them
	assign local_out  = cfg_q.loc_reg ? cell_q : comb_out;                 // [R3]
	assign global_out = cfg_q.glb_reg ? cell_q : comb_out;                 // [R3]

	// clock enable; without first-input enable the register is enabled on every edge
	assign ce = cfg_q.ce_d1 ? first_data_input : 1'b1;                     // [R23]

	// asynchronous control decode from third input and the two block controls
	assign dev_rst = cfg_q.dev_rst_en & ~device_reset_n;
	always_comb begin
		actl.clr_n = 1'b1;                                                 // [R14]
		actl.pre_n = 1'b1;                                                 // [R14]
		actl.inv   = 1'b0;
		case (cfg_q.ctl)
			CTL_CLR: begin
				actl.clr_n = ~(block_control_one | block_control_two);    // [R18] [R12]
			end
			CTL_PRE: begin
				// third input treated as tied high, so control one loads a one
				actl.pre_n = ~block_control_one;                          // [R19]
			end
			CTL_CLR_PRE: begin
				actl.pre_n = ~block_control_one;                          // [R20]
				actl.clr_n = ~block_control_two;                          // [R20]
			end
			CTL_LOAD_CLR: begin
				actl.pre_n = ~(block_control_one & third_data_input);     // [R21] [R13]
				actl.clr_n = ~((block_control_one & ~third_data_input) |
				               block_control_two);                        // [R21]
			end
			CTL_LOAD_PRE: begin
				// stored inverted: preset of the cell is a clear of the flop
				actl.inv   = 1'b1;                                        // [R22]
				actl.pre_n = ~(block_control_one & ~third_data_input);    // [R22] [R13]
				actl.clr_n = ~((block_control_one & third_data_input) |
				               block_control_two);                        // [R22]
			end
			CTL_LOAD: begin
				actl.pre_n = ~(block_control_one & third_data_input);     // [R13] [R15]
				actl.clr_n = ~(block_control_one & ~third_data_input);    // [R13] [R15]
			end
			default: begin
				actl.clr_n = 1'b1;
				actl.pre_n = 1'b1;
			end
		endcase
		// device reset wins: clear forced, preset released
		if (dev_rst) begin
			actl.clr_n = 1'b0;                                             // [R16]
			actl.pre_n = 1'b1;                                             // [R16]
		end
	end

	assign store_d = actl.inv ? ~reg_d : reg_d;

	// the cell register; asynchronous controls come from decoded fabric lines,
	// so glitches on those lines can disturb it, exactly as in the fabric cell
	always_ff @(posedge pclk or negedge presetn or negedge actl.clr_n or
	            negedge actl.pre_n) begin
		if (!presetn) begin
			store_q <= 1'b0;
		end else if (!actl.clr_n) begin
			store_q <= 1'b0;                                               // [R8] [R16]
		end else if (!actl.pre_n) begin
			store_q <= 1'b1;                                               // [R8]
		end else if (ce) begin
			store_q <= store_d;                                            // [R24] [R2]
		end
	end

	// inverted storage means a reset cell may read one
	assign cell_q = store_q ^ actl.inv;                                    // [R17]

	// emulated internal bus: contention resolves low, no driver resolves high
	always_comb begin
		tri_cnt = 3'h0;
		for (int i = 0; i < LCRM_TRI_N; i++) begin
			tri_cnt = tri_cnt + {2'b00, tri_enable[i]};
		end
	end
	assign tri_sel     = tri_data & tri_enable;
	assign tri_bus_out = (tri_cnt == 3'h0) ? 1'b1 :
	                     (tri_cnt == 3'h1) ? (|tri_sel) : 1'b0;            // [R11]

	// checks
	a_packed_input: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q.op == OP_NORMAL && cfg_q.packed_en) |-> reg_d == fourth_data_input) // [R1]
		else $error("packed register not fed by fourth input");

	a_reg_capture: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && actl.clr_n && actl.pre_n && $stable(cfg_q)) ##1
		(actl.clr_n && actl.pre_n && $stable(cfg_q)) |-> cell_q == $past(reg_d)) // [R24]
		else $error("enabled register did not capture its input");

	a_arith_carry: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q.op == OP_ARITH) |->
		carry_out == lut_q[{1'b1, carry_in, second_data_input, first_data_input}]) // [R4]
		else $error("carry-out does not follow the carry table");

	a_sync_load: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q.op == OP_UPDOWN && fourth_data_input && ce && actl.clr_n && actl.pre_n)
		##1 (actl.clr_n && actl.pre_n && $stable(cfg_q))
		|-> cell_q == $past(third_data_input))                             // [R7]
		else $error("synchronous load missed");

	a_sync_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q.op == OP_CLRCNT && cascade_in && ce && actl.clr_n && actl.pre_n)
		##1 (actl.clr_n && actl.pre_n && $stable(cfg_q)) |-> !cell_q)      // [R10]
		else $error("synchronous clear did not force zero");

	a_bus_resolve: assert property (@(posedge pclk) disable iff (!presetn)
		($countones(tri_enable) > 1 |-> !tri_bus_out) and
		(tri_enable == '0 |-> tri_bus_out))                                // [R11]
		else $error("emulated bus resolved wrongly");

	a_async_load: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q.ctl == CTL_LOAD && !dev_rst && block_control_one &&
		 $past(block_control_one) && $stable(third_data_input) && $stable(cfg_q))
		|-> cell_q == third_data_input)                                    // [R13]
		else $error("asynchronous load did not take third input");

	a_dev_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(dev_rst && $past(dev_rst) && $stable(cfg_q)) |-> cell_q == actl.inv) // [R16]
		else $error("device reset did not override register");

	// two parts: preset stays idle, and a held control line keeps the cell clear
	a_clear_only: assert property (@(posedge pclk) disable iff (!presetn)
		((cfg_q.ctl == CTL_CLR) |-> actl.pre_n) and
		((cfg_q.ctl == CTL_CLR) && (block_control_one || block_control_two) &&
		 $past(block_control_one || block_control_two) && $stable(cfg_q) |-> !cell_q)) // [R18]
		else $error("clear-only mode misbehaved");

	a_split_outputs: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(cfg_q.op == OP_NORMAL && cfg_q.packed_en && cfg_q.glb_reg && !cfg_q.loc_reg)
		|-> (global_out == cell_q && local_out == lut3))
		else $error("packed outputs not split between register and lut");

	a_arith_cascade: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(cfg_q.op == OP_ARITH) |-> cascade_out == (sum_bit & cascade_in))
		else $error("cascade path lost in arithmetic mode");

	a_async_sources: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(!block_control_one && !block_control_two && !dev_rst) |->
		(actl.clr_n && actl.pre_n))
		else $error("async control active without a block control line");

	a_dev_priority: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		dev_rst |-> (!actl.clr_n && actl.pre_n))
		else $error("device reset did not take priority");

	a_preset_only: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		(cfg_q.ctl == CTL_PRE && !dev_rst) |->
		(actl.clr_n && actl.pre_n == !block_control_one))
		else $error("preset-only decode wrong");

	a_clear_preset: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		(cfg_q.ctl == CTL_CLR_PRE && !dev_rst) |->
		(actl.pre_n == !block_control_one && actl.clr_n == !block_control_two))
		else $error("clear-with-preset decode wrong");

	a_load_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		(cfg_q.ctl == CTL_LOAD_CLR && !dev_rst && !block_control_one) |->
		(actl.pre_n && actl.clr_n == !block_control_two))
		else $error("load-with-clear: control two drove more than clear");

	a_load_preset: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q.ctl == CTL_LOAD_PRE && !dev_rst && block_control_two && !block_control_one
		 && $past(block_control_two) && $stable(cfg_q)) |-> cell_q)      // [R22]
		else $error("load-with-preset did not preset");

endmodule : lcrm_cell

// >>> lcrm_fabric.sv
// Purpose: model of the routing fabric and neighbour cells feeding one cell
// Assumes: requests come from the bench and land at the next rising edge
// Notes:   control lines default inactive so nothing floats into the cell
`timescale 1ns/100ps
module lcrm_fabric
	import lcrm_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic [8:0]            want,
	input  wire logic [LCRM_TRI_N-1:0] want_td,
	input  wire logic [LCRM_TRI_N-1:0] want_te,
	output logic      [8:0]            drv,
	output logic      [LCRM_TRI_N-1:0] tri_data,
	output logic      [LCRM_TRI_N-1:0] tri_enable
);
	// registered drive, like a neighbour flop; device reset line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv        <= 9'h100;
			tri_data   <= '0;
			tri_enable <= '0;
		end else begin
			drv        <= want;
			tri_data   <= want_td;
			tri_enable <= want_te;
		end
	end
endmodule : lcrm_fabric

// >>> tb_logic_cell_register_modes.sv
// Purpose: self-checking bench for the programmable logic cell
// Assumes: fabric model applies each input request one edge later
// Notes:   driver queues expectations, a monitor pops and compares them
`timescale 1ns/100ps
module tb_logic_cell_register_modes;
	import lcrm_pkg::*;
	typedef struct packed {
		logic        src;
		logic [31:0] m;
		logic [31:0] v;
	} lcrm_exp_s;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	// up/down and clearable steps: op, exp carry, exp q, fabric word
	localparam logic [15:0] CNT [0:8] = '{16'hB132, 16'h8132, 16'h9112, 16'h9110,
		16'hA11A, 16'h911E, 16'hC13E, 16'hD11E, 16'hC132};
	localparam logic [5:0] E1D0 = 6'h06;
	localparam logic [5:0] E1D1 = 6'h3E;
	localparam logic [5:0] B2M  = 6'h1D;
	localparam logic [5:0] B2V  = 6'h10;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rd, obs, r;
	logic [8:0]            want, drv;
	logic [LCRM_TRI_N-1:0] want_td, want_te, tri_data, tri_enable;
	logic                  local_out, global_out, carry_out, cascade_out, tri_bus_out;
	logic                  x, mj;
	lcrm_exp_s             eq[$];
	lcrm_exp_s             e;
	int                    error_cnt, compares, cyc, k;
	integer                seed;
	event                  look;

	lcrm_cell i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_data_input(drv[0]), .second_data_input(drv[1]),
		.third_data_input(drv[2]), .fourth_data_input(drv[3]), .carry_in(drv[4]),
		.cascade_in(drv[5]), .block_control_one(drv[6]), .block_control_two(drv[7]),
		.device_reset_n(drv[8]), .tri_data(tri_data), .tri_enable(tri_enable),
		.local_out(local_out), .global_out(global_out), .carry_out(carry_out),
		.cascade_out(cascade_out), .tri_bus_out(tri_bus_out));
	lcrm_fabric i_fab (.pclk(pclk), .presetn(presetn), .want(want), .want_td(want_td),
		.want_te(want_te), .drv(drv), .tri_data(tri_data), .tri_enable(tri_enable));

	// free-running 40 MHz clock
	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic chk(input logic s, input logic [31:0] m, input logic [31:0] v);
		@(negedge pclk);
		eq.push_back('{s, m, v});
		-> look;
	endtask : chk

	// two edges: one for the fabric flop, one for a synchronous capture
	task automatic drive(input logic [8:0] w);
		@(posedge pclk);
		want <= w;
		repeat (2) @(posedge pclk);
	endtask : drive

	// exactly one enabled edge, clock enable taken from the first input
	task automatic step(input logic [8:0] w);
		drive(w);
		want <= w | 9'h001;
		@(posedge pclk);
		want <= w;
		repeat (2) @(posedge pclk);
	endtask : step

	task automatic print_verdict;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	// monitor: oldest expectation against what the cell shows now
	always @(look) begin
		e = eq.pop_front();
		obs = e.src ? {26'h0, err, tri_bus_out, cascade_out, carry_out, global_out, local_out} : rd;
		compares++;
		if ((obs & e.m) !== e.v) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, obs & e.m, e.v);
		end
	end

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		seed = 32'h83f14e20;
		{psel, penable, pwrite, err} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		want = 9'h100;
		{want_td, want_te} = 8'h00;
		presetn = 1'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		apb(0, LCRM_ADDR_CFG, 0);
		chk(0, ALL, 32'h0);
		apb(1, LCRM_ADDR_STAT, ALL);
		apb(0, LCRM_ADDR_STAT, 0);
		chk(0, ALL, 32'h8);
		apb(0, 12'h00C, 0);
		chk(1, 32'h20, 32'h20);
		chk(0, ALL, 32'h0);
		apb(1, LCRM_ADDR_LUT, 32'hFFFF_A5C3);
		apb(0, LCRM_ADDR_LUT, 0);
		chk(0, ALL, 32'h0000_A5C3);
		// packed: register from fourth input, lut on the others, outputs swapped
		apb(1, LCRM_ADDR_LUT, 32'h00E8);
		for (k = 0; k < 8; k++) begin
			r = $random(seed);
			apb(1, LCRM_ADDR_CFG, k[0] ? 32'h2A0 : 32'h260);
			mj = r[2] & r[1];
			step({5'h10, r[3:1], 1'h0});
			chk(1, 32'h3, k[0] ? {30'h0, r[3], mj} : {30'h0, mj, r[3]});
			drive({5'h10, ~r[3], r[2:1], 1'h0});
			chk(1, 32'h3, k[0] ? {30'h0, r[3], mj} : {30'h0, mj, r[3]});
		end
		drive(9'h188);
		chk(1, 32'h2, 32'h0);
		drive(9'h100);
		// arithmetic: sum and carry luts, cascade gated by the sum
		apb(1, LCRM_ADDR_LUT, 32'hE896);
		apb(1, LCRM_ADDR_CFG, 32'h201);
		for (k = 0; k < 8; k++) begin
			r = $random(seed);
			x = r[0] ^ r[1] ^ r[4];
			mj = (r[0] & r[1]) | (r[4] & (r[0] | r[1]));
			drive({3'h4, r[5:4], 2'h0, r[1:0]});
			chk(1, 32'hF, {28'h0, x & r[5], mj, x, x});
		end
		// counters, stepped one enabled edge at a time from a cleared register
		apb(1, LCRM_ADDR_CFG, 32'h242);
		drive(9'h140);
		drive(9'h100);
		for (k = 0; k < 9; k++) begin
			apb(1, LCRM_ADDR_CFG, {30'h0, CNT[k][15:14]} | 32'h240);
			step(CNT[k][8:0]);
			chk(1, CNT[k][14] ? 32'h1 : 32'h5, {29'h0, CNT[k][13], 1'h0, CNT[k][12]});
		end
		// the six clear and preset modes, clock held off
		for (k = 0; k < 6; k++) begin
			apb(1, LCRM_ADDR_CFG, {27'h0, k[2:0], 2'h0} | 32'h240);
			drive(9'h140);
			chk(1, 32'h1, {31'h0, E1D0[k]});
			drive(9'h144);
			chk(1, 32'h1, {31'h0, E1D1[k]});
			drive(9'h100);
			if (B2M[k]) begin
				drive(9'h180);
				chk(1, 32'h1, {31'h0, B2V[k]});
				drive(9'h100);
			end
		end
		// device reset over a pending load, inverted preset, and disabled
		apb(1, LCRM_ADDR_CFG, 32'h354);
		drive(9'h044);
		chk(1, 32'h1, 32'h0);
		apb(1, LCRM_ADDR_CFG, 32'h350);
		drive(9'h000);
		chk(1, 32'h1, 32'h1);
		apb(1, LCRM_ADDR_CFG, 32'h254);
		drive(9'h044);
		chk(1, 32'h1, 32'h1);
		drive(9'h100);
		// emulated bus over every enable pattern
		for (k = 0; k < 16; k++) begin
			r = $random(seed);
			@(posedge pclk);
			want_td <= r[3:0];
			want_te <= k[3:0];
			repeat (2) @(posedge pclk);
			x = ($countones(k[3:0]) == 0) ? 1'h1 :
				($countones(k[3:0]) > 1) ? 1'h0 : |(r[3:0] & k[3:0]);
			chk(1, 32'h10, {27'h0, x, 4'h0});
		end
		print_verdict();
	end
endmodule : tb_logic_cell_register_modes
